// [design/pbmc_regs.sv]
`timescale 1ns/10ps
`default_nettype none

// Function
// - self-clearing bits act, then clear themselves
// - soft reset forces typed fields to defaults
// - strap fields default from pins at power-on
// - decode basic registers plus extended pointer/window
// - control bit 15 resets state machines
// - soft reset end restores control and status
// - control bit 14 enables internal loopback
// - bits 6,13 select speed; AN reports
// - control bit 12 enables auto-negotiation
// - bit 11 powers down, management stays alive
// - isolate ignores transmit data and control
// - isolate floats receive clock, control, data
// - management works while isolated
// - control bit 9 restarts auto-negotiation
// - bit 8 sets duplex without AN
// - bit 8 reports resolved duplex after AN
// - control bit 7 enables collision test
// - soft reset does not resample straps
module pbmc_regs
  import pbmc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        mdcPin,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOeN,
  input  wire logic        strapAutonegEnable,
  input  wire logic [1:0]  strapPhyAddr,
  input  wire logic        anComplete,
  input  wire logic        anSpeed100,
  input  wire logic        anFullDuplex,
  input  wire logic        linkUp,
  input  wire logic        remoteFaultIn,
  input  wire logic        jabberIn,
  input  wire logic [15:0] partnerAbility,
  input  wire logic [3:0]  txDataPin,
  input  wire logic        transmitControlIn,
  output logic [3:0]       txDataCore,
  output logic             txCtlCore,
  input  wire logic        coreRxClk,
  input  wire logic        coreRxCtl,
  input  wire logic [3:0]  coreRxData,
  output logic             receiveClockOut,
  output logic             receiveClockOeN,
  output logic             receiveControlOut,
  output logic             receiveControlOeN,
  output logic [3:0]       rxDataOut,
  output logic             rxDataOeN,
  output logic             phyStateReset,
  output logic             loopbackEn,
  output logic             speed100,
  output logic             fullDuplex,
  output logic             autonegEnable,
  output logic             autonegRestart,
  output logic             powerDown,
  output logic             isolate,
  output logic             collisionTest
);
  import pbmc_pkg::*;

  logic [2:0]       mdcSync;
  logic             mdcLevel;
  logic             mdcRise;
  logic [2:0]       mdioSync;
  logic             mdioBit;
  logic [2:0]       strapSyncAn;
  logic [5:0]       strapSyncAddr;
  logic [1:0]       strapWait;
  logic             strapTaken;
  logic             strapAn;
  logic [1:0]       myAddrLow;
  logic [4:0]       myAddr;

  pbmc_state_e      state;
  logic [3:0]       bitCnt;
  logic [11:0]      hdr;
  logic [15:0]      shiftIn;
  logic [15:0]      shiftOut;
  logic             readMine;
  logic             writeMine;
  logic             regWrite;
  logic [4:0]       wrAddr;
  logic [15:0]      wrData;
  logic             readTake;
  logic [15:0]      readValue;

  logic             softBusy;
  logic [7:0]       softCnt;
  logic             softDone;
  logic             ctlLoop;
  logic             ctlSpeedLo;
  logic             ctlAnEn;
  logic             ctlPwd;
  logic             ctlIso;
  logic             ctlDuplex;
  logic             ctlColTest;
  logic             ctlSpeedHi;
  logic             anResolved;
  logic             rfaultLatched;
  logic             linkLatched;

  logic [15:0]      anAdv;
  logic [15:0]      anNpTx;
  logic [15:0]      c45Ctrl;
  logic [15:0]      c45Data;
  logic [15:0]      phyCtrl;
  logic [15:0]      intEnable;
  logic [15:0]      speedCfg;
  logic [15:0]      extPointer;
  logic [15:0]      extMem [0:EXT_DEPTH-1];
  logic [15:0]      controlWord;
  logic [15:0]      statusWord;

  // three-stage synchronisers for the management clock and data pins
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      mdcSync  <= 3'h0;
      mdioSync <= 3'h7;
      mdcLevel <= 1'b0;
    end
    else
    begin
      mdcSync  <= {mdcSync[1:0], mdcPin};
      mdioSync <= {mdioSync[1:0], mdioIn};
      if (mdcSync[1] == mdcSync[2])
        mdcLevel <= mdcSync[2];
    end
  end

  // a rising edge counts once stages two and three agree on the new high level
  assign mdcRise = (mdcSync[1] == mdcSync[2]) && mdcSync[2] && !mdcLevel;
  assign mdioBit = mdioSync[2];

  // straps synchronised, then taken once after hardware reset release
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      strapSyncAn   <= 3'h0;
      strapSyncAddr <= 6'h00;
      strapWait     <= 2'h0;
      strapTaken    <= 1'b0;
      strapAn       <= 1'b1;
      myAddrLow     <= 2'h0;
    end
    else
    begin
      strapSyncAn   <= {strapSyncAn[1:0], strapAutonegEnable};
      strapSyncAddr <= {strapSyncAddr[3:0], strapPhyAddr};
      if (!strapTaken)
      begin
        if (strapWait == STRAP_SETTLE)
        begin
          strapTaken <= 1'b1;
          strapAn    <= strapSyncAn[2];
          myAddrLow  <= strapSyncAddr[5:4];
        end
        else
          strapWait <= strapWait + 2'h1;
      end
    end
  end

  assign myAddr = {3'h0, myAddrLow};

  // header decode: opcode, station address, register number
  assign readMine  = (hdr[11:10] == OP_READ) && (hdr[9:5] == myAddr);
  assign writeMine = (hdr[11:10] == OP_WRITE) && (hdr[9:5] == myAddr);

  // serial frame engine, alive in every mode of the datapath
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state    <= PBMC_IDLE;
      bitCnt   <= 4'h0;
      hdr      <= 12'h000;
      shiftIn  <= 16'h0000;
      shiftOut <= 16'h0000;
      mdioOut  <= 1'b1;
      mdioOeN  <= 1'b1;
      regWrite <= 1'b0;
      readTake <= 1'b0;
      wrAddr   <= 5'h00;
      wrData   <= 16'h0000;
    end
    else
    begin
      regWrite <= 1'b0;
      readTake <= 1'b0;
      if (mdcRise)
      begin
        case (state)
          PBMC_IDLE:
          begin
            if (!mdioBit)
              state <= PBMC_START;
          end
          PBMC_START:
          begin
            bitCnt <= 4'h0;
            state  <= mdioBit ? PBMC_HDR : PBMC_START;
          end
          PBMC_HDR:
          begin
            hdr <= {hdr[10:0], mdioBit};
            if (bitCnt == HDR_LAST)
            begin
              bitCnt <= 4'h0;
              state  <= PBMC_TA;
            end
            else
              bitCnt <= bitCnt + 4'h1;
          end
          PBMC_TA:
          begin
            if (bitCnt == 4'h0)
            begin
              bitCnt <= 4'h1;
              if (readMine)
              begin
                mdioOeN  <= 1'b0;
                mdioOut  <= 1'b0;
                shiftOut <= readValue;
                readTake <= 1'b1;
              end
            end
            else
            begin
              bitCnt <= 4'h0;
              state  <= PBMC_DATA;
              if (readMine)
              begin
                mdioOut  <= shiftOut[15];
                shiftOut <= {shiftOut[14:0], 1'b0};
              end
            end
          end
          PBMC_DATA:
          begin
            shiftIn <= {shiftIn[14:0], mdioBit};
            if (readMine)
            begin
              mdioOut  <= shiftOut[15];
              shiftOut <= {shiftOut[14:0], 1'b0};
            end
            if (bitCnt == DATA_LAST)
            begin
              state   <= PBMC_IDLE;
              mdioOeN <= 1'b1;
              mdioOut <= 1'b1;
              if (writeMine)
              begin
                regWrite <= 1'b1;
                wrAddr   <= hdr[4:0];
                wrData   <= {shiftIn[14:0], mdioBit};
              end
            end
            else
              bitCnt <= bitCnt + 4'h1;
          end
          default:
            state <= PBMC_IDLE;
        endcase
      end
    end
  end

  // soft reset sequencer: bit 15 stays set until the reset is done
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      softBusy <= 1'b0;
      softCnt  <= 8'h00;
    end
    else if (softBusy)
    begin
      if (softCnt == SOFT_RESET_LAST)
        softBusy <= 1'b0;
      else
        softCnt <= softCnt + 8'h01;
    end
    else if (regWrite && wrAddr == REG_CONTROL && wrData[CTL_RESET])
    begin
      softBusy <= 1'b1;
      softCnt  <= 8'h00;
    end
  end

  assign softDone = softBusy && (softCnt == SOFT_RESET_LAST);
  assign phyStateReset = softBusy;

  // control fields; strap default reused on soft reset without resampling
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || softDone)
    begin
      ctlLoop    <= CTL_LOOPBACK_DEF;
      ctlSpeedLo <= CTL_SPEED_LO_DEF;
      ctlAnEn    <= nrst ? strapAn : 1'b1;
      ctlPwd     <= CTL_PWR_DOWN_DEF;
      ctlIso     <= CTL_ISOLATE_DEF;
      ctlDuplex  <= CTL_DUPLEX_DEF;
      ctlColTest <= CTL_COL_TEST_DEF;
      ctlSpeedHi <= CTL_SPEED_HI_DEF;
    end
    else if (strapTaken == 1'b0 && strapWait == STRAP_SETTLE)
      ctlAnEn <= strapSyncAn[2];
    else if (regWrite && wrAddr == REG_CONTROL && !wrData[CTL_RESET] && !softBusy)
    begin
      ctlLoop    <= wrData[CTL_LOOPBACK];
      ctlSpeedLo <= wrData[CTL_SPEED_LO];
      ctlAnEn    <= wrData[CTL_AN_ENABLE];
      ctlPwd     <= wrData[CTL_PWR_DOWN];
      ctlIso     <= wrData[CTL_ISOLATE];
      ctlDuplex  <= wrData[CTL_DUPLEX];
      ctlColTest <= wrData[CTL_COL_TEST];
      ctlSpeedHi <= wrData[CTL_SPEED_HI];
    end
  end

  // restart pulse: acts on the write, the bit never reads back as set
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      autonegRestart <= 1'b0;
    else
      autonegRestart <= regWrite && wrAddr == REG_CONTROL && !wrData[CTL_RESET]
                        && wrData[CTL_AN_RESTART] && !softBusy;
  end

  // status latches: remote fault clears on read, link latches low
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || softDone)
    begin
      rfaultLatched <= 1'b0;
      linkLatched   <= 1'b0;
    end
    else
    begin
      if (remoteFaultIn)
        rfaultLatched <= 1'b1;
      else if (readTake && hdr[4:0] == REG_STATUS)
        rfaultLatched <= 1'b0;
      if (!linkUp)
        linkLatched <= 1'b0;
      else if (readTake && hdr[4:0] == REG_STATUS)
        linkLatched <= 1'b1;
    end
  end

  // plain read/write words and the extended window pointer
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      anAdv      <= RW_RESET;
      anNpTx     <= RW_RESET;
      c45Ctrl    <= RW_RESET;
      c45Data    <= RW_RESET;
      phyCtrl    <= RW_RESET;
      intEnable  <= RW_RESET;
      speedCfg   <= RW_RESET;
      extPointer <= RW_RESET;
    end
    else if (regWrite)
    begin
      case (wrAddr)
        REG_AN_ADV:      anAdv      <= wrData;
        REG_AN_NP_TX:    anNpTx     <= wrData;
        REG_C45_CTRL:    c45Ctrl    <= wrData;
        REG_C45_DATA:    c45Data    <= wrData;
        REG_PHY_CTRL:    phyCtrl    <= wrData;
        REG_INT_ENABLE:  intEnable  <= wrData;
        REG_SPEED_CFG:   speedCfg   <= wrData;
        REG_EXT_POINTER: extPointer <= wrData;
        default:         anAdv      <= anAdv;
      endcase
    end
  end

  // extended register storage behind the window
  always_ff @(posedge sys_clk)
  begin
    if (regWrite && wrAddr == REG_EXT_WINDOW)
      extMem[extPointer[EXT_AW-1:0]] <= wrData;
  end

  // resolved values replace speed bit 13 and the duplex bit after negotiation; bit 6 keeps its written value
  assign anResolved = ctlAnEn && anComplete;

  // control and status words as read
  always_comb
  begin
    controlWord                 = 16'h0000;
    controlWord[CTL_RESET]      = softBusy;
    controlWord[CTL_LOOPBACK]   = ctlLoop;
    controlWord[CTL_SPEED_LO]   = anResolved ? anSpeed100 : ctlSpeedLo;
    controlWord[CTL_AN_ENABLE]  = ctlAnEn;
    controlWord[CTL_PWR_DOWN]   = ctlPwd;
    controlWord[CTL_ISOLATE]    = ctlIso;
    controlWord[CTL_DUPLEX]     = anResolved ? anFullDuplex : ctlDuplex;
    controlWord[CTL_COL_TEST]   = ctlColTest;
    controlWord[CTL_SPEED_HI]   = ctlSpeedHi;
    statusWord                  = STATUS_FIXED;
    statusWord[STS_AN_DONE]     = anComplete;
    statusWord[STS_RFAULT]      = rfaultLatched;
    statusWord[STS_LINK]        = linkLatched;
    statusWord[STS_JABBER]      = jabberIn;
  end

  // read multiplexer; unmapped numbers read zero
  always_comb
  begin
    case (hdr[4:0])
      REG_CONTROL:      readValue = controlWord;
      REG_STATUS:       readValue = statusWord;
      REG_ID_HIGH:      readValue = ID_HIGH_VALUE;
      REG_ID_LOW:       readValue = ID_LOW_VALUE;
      REG_AN_ADV:       readValue = anAdv;
      REG_AN_PARTNER:   readValue = partnerAbility;
      REG_AN_EXPANSION: readValue = 16'h0000;
      REG_AN_NP_TX:     readValue = anNpTx;
      REG_AN_NP_RX:     readValue = 16'h0000;
      REG_MS_STATUS:    readValue = 16'h0000;
      REG_C45_CTRL:     readValue = c45Ctrl;
      REG_C45_DATA:     readValue = c45Data;
      REG_PHY_CTRL:     readValue = phyCtrl;
      REG_PHY_STATUS:   readValue = {12'h000, linkUp, anComplete, speed100, fullDuplex};
      REG_INT_ENABLE:   readValue = intEnable;
      REG_INT_STATUS:   readValue = 16'h0000;
      REG_SPEED_CFG:    readValue = speedCfg;
      REG_RX_ERR_CNT:   readValue = 16'h0000;
      REG_EXT_POINTER:  readValue = extPointer;
      REG_EXT_WINDOW:   readValue = extMem[extPointer[EXT_AW-1:0]];
      default:          readValue = 16'h0000;
    endcase
  end

  // mode outputs to the datapath
  assign loopbackEn    = ctlLoop;
  assign speed100      = controlWord[CTL_SPEED_LO] && !ctlSpeedHi;
  assign fullDuplex    = controlWord[CTL_DUPLEX];
  assign autonegEnable = ctlAnEn;
  assign powerDown     = ctlPwd;
  assign isolate       = ctlIso;
  assign collisionTest = ctlColTest;

  // isolation of the mac data pins
  assign txDataCore        = ctlIso ? 4'h0 : txDataPin;
  assign txCtlCore         = ctlIso ? 1'b0 : transmitControlIn;
  assign receiveClockOut   = coreRxClk;
  assign receiveControlOut = coreRxCtl;
  assign rxDataOut         = coreRxData;
  assign receiveClockOeN   = ctlIso;
  assign receiveControlOeN = ctlIso;
  assign rxDataOeN         = ctlIso;

endmodule

`default_nettype wire

// [design/pbmc_pkg.sv]
package pbmc_pkg;

  // register numbers of the management space
  localparam logic [4:0] REG_CONTROL      = 5'h00;
  localparam logic [4:0] REG_STATUS       = 5'h01;
  localparam logic [4:0] REG_ID_HIGH      = 5'h02;
  localparam logic [4:0] REG_ID_LOW       = 5'h03;
  localparam logic [4:0] REG_AN_ADV       = 5'h04;
  localparam logic [4:0] REG_AN_PARTNER   = 5'h05;
  localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
  localparam logic [4:0] REG_AN_NP_TX     = 5'h07;
  localparam logic [4:0] REG_AN_NP_RX     = 5'h08;
  localparam logic [4:0] REG_MS_STATUS    = 5'h0a;
  localparam logic [4:0] REG_C45_CTRL     = 5'h0d;
  localparam logic [4:0] REG_C45_DATA     = 5'h0e;
  localparam logic [4:0] REG_PHY_CTRL     = 5'h10;
  localparam logic [4:0] REG_PHY_STATUS   = 5'h11;
  localparam logic [4:0] REG_INT_ENABLE   = 5'h12;
  localparam logic [4:0] REG_INT_STATUS   = 5'h13;
  localparam logic [4:0] REG_SPEED_CFG    = 5'h14;
  localparam logic [4:0] REG_RX_ERR_CNT   = 5'h15;
  localparam logic [4:0] REG_EXT_POINTER  = 5'h1e;
  localparam logic [4:0] REG_EXT_WINDOW   = 5'h1f;

  // control register bit positions
  localparam int CTL_RESET     = 15;
  localparam int CTL_LOOPBACK  = 14;
  localparam int CTL_SPEED_LO  = 13;
  localparam int CTL_AN_ENABLE = 12;
  localparam int CTL_PWR_DOWN  = 11;
  localparam int CTL_ISOLATE   = 10;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_DUPLEX    = 8;
  localparam int CTL_COL_TEST  = 7;
  localparam int CTL_SPEED_HI  = 6;

  // control field defaults
  localparam logic CTL_LOOPBACK_DEF = 1'b0;
  localparam logic CTL_SPEED_LO_DEF = 1'b1;
  localparam logic CTL_PWR_DOWN_DEF = 1'b0;
  localparam logic CTL_ISOLATE_DEF  = 1'b0;
  localparam logic CTL_DUPLEX_DEF   = 1'b1;
  localparam logic CTL_COL_TEST_DEF = 1'b0;
  localparam logic CTL_SPEED_HI_DEF = 1'b0;

  // status register: fixed ability bits and live bit positions
  localparam logic [15:0] STATUS_FIXED = 16'h7949;
  localparam int STS_AN_DONE  = 5;
  localparam int STS_RFAULT   = 4;
  localparam int STS_LINK     = 2;
  localparam int STS_JABBER   = 1;

  // identifier words, values arbitrary
  localparam logic [15:0] ID_HIGH_VALUE = 16'h1234;
  localparam logic [15:0] ID_LOW_VALUE  = 16'h5678;

  // reset value of the plain read/write words
  localparam logic [15:0] RW_RESET = 16'h0000;

  // serial frame codes
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] OP_READ  = 2'b10;
  localparam logic [3:0] HDR_LAST = 4'hb;
  localparam logic [3:0] DATA_LAST = 4'hf;

  // extended window storage
  localparam int EXT_DEPTH = 16;
  localparam int EXT_AW    = 4;

  // internal soft reset duration
  localparam int SYS_CLK_MHZ = 40;
  localparam int SOFT_RESET_HOLD_NS = 1000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SOFT_RESET_LAST = 8'(SOFT_RESET_CYCLES - 1);

  // cycles to wait before taking straps
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [4:0] {
    PBMC_IDLE  = 5'b00001,
    PBMC_START = 5'b00010,
    PBMC_HDR   = 5'b00100,
    PBMC_TA    = 5'b01000,
    PBMC_DATA  = 5'b10000
  } pbmc_state_e;

endpackage

// [tb/pbmc_regs_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module pbmc_regs_chk
  import pbmc_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       mdioOut,
  input wire logic       mdioOeN,
  input wire logic [3:0] txDataPin,
  input wire logic       transmitControlIn,
  input wire logic [3:0] txDataCore,
  input wire logic       txCtlCore,
  input wire logic       coreRxClk,
  input wire logic [3:0] coreRxData,
  input wire logic       receiveClockOut,
  input wire logic       receiveClockOeN,
  input wire logic       receiveControlOeN,
  input wire logic [3:0] rxDataOut,
  input wire logic       rxDataOeN,
  input wire logic       phyStateReset,
  input wire logic       autonegRestart,
  input wire logic       loopbackEn,
  input wire logic       powerDown,
  input wire logic       isolate,
  input wire logic       collisionTest
);
  logic [7:0] srstCnt;

  // length of the running soft reset
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !phyStateReset)
      srstCnt <= 8'h00;
    else
      srstCnt <= srstCnt + 8'h01;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_rx_float;
    {receiveClockOeN, receiveControlOeN, rxDataOeN} == {3{isolate}};
  endproperty
  a_rx_float: assert property (p_rx_float) else $error("rx enables off");
  property p_tx_block;
    isolate |-> txDataCore == 4'h0 && !txCtlCore;
  endproperty
  a_tx_block: assert property (p_tx_block) else $error("tx not blocked");
  property p_tx_pass;
    !isolate |-> txDataCore == txDataPin && txCtlCore == transmitControlIn;
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("tx not passed");
  property p_rx_pass;
    receiveClockOut == coreRxClk && rxDataOut == coreRxData;
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("rx not passed");
  property p_restart;
    autonegRestart |=> !autonegRestart;
  endproperty
  a_restart: assert property (p_restart) else $error("restart too long");
  property p_srst_len;
    $fell(phyStateReset) |-> srstCnt == 8'(SOFT_RESET_CYCLES);
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("soft reset length");
  property p_srst_def;
    $fell(phyStateReset) |-> ##[0:2] !(loopbackEn | powerDown | isolate | collisionTest);
  endproperty
  a_srst_def: assert property (p_srst_def) else $error("defaults not back");
  property p_turn;
    $fell(mdioOeN) |-> !mdioOut ##1 (!mdioOeN) [*8];
  endproperty
  a_turn: assert property (p_turn) else $error("bad turnaround");
  property p_idle;
    mdioOeN |-> mdioOut;
  endproperty
  a_idle: assert property (p_idle) else $error("idle level");

  // main scenarios reached
  c_iso: cover property (isolate);
  c_srst: cover property ($fell(phyStateReset));
  c_restart: cover property (autonegRestart);
  c_read: cover property ($fell(mdioOeN));
endmodule

bind pbmc_regs pbmc_regs_chk i_chk (.sys_clk, .nrst, .mdioOut, .mdioOeN, .txDataPin,
  .transmitControlIn, .txDataCore, .txCtlCore, .coreRxClk, .coreRxData, .receiveClockOut,
  .receiveClockOeN, .receiveControlOeN, .rxDataOut, .rxDataOeN, .phyStateReset,
  .autonegRestart, .loopbackEn, .powerDown, .isolate, .collisionTest);
`default_nettype wire

// [tb/pbmc_mgr_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pbmc_mgr_model
  import pbmc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic mdioLine,
  output logic      mdcPin,
  output logic      mgrOut,
  output logic      mgrOeN
);
  // clock rests low and the line is released outside frames
  initial
  begin
    mdcPin = 1'b0;
    mgrOut = 1'b1;
    mgrOeN = 1'b1;
  end

  // one bit: data set while clock low, line sampled just before the rise
  task automatic bit_cell(input logic oeN, input logic v, output logic s);
    mgrOeN = oeN;
    mgrOut = v;
    mdcPin = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    s = mdioLine;
    mdcPin = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // whole frame with preamble; a read lets go of the line from turnaround on
  task automatic frame(input logic [4:0] phy, input logic rd, input logic [4:0] regNum,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [63:0] bits;
    logic        s;
    bits = {32'hffff_ffff, 2'b01, (rd ? OP_READ : OP_WRITE), phy, regNum, 2'b10, wdata};
    rdata = 16'h0000;
    for (int i = 63; i >= 0; i--)
    begin
      bit_cell(rd && (i < 18), bits[i], s);
      if (i < 16)
        rdata[i] = s;
    end
    mgrOeN = 1'b1;
    mdcPin = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// [tb/pbmc_regs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module pbmc_regs_tb_top;
  import pbmc_pkg::*;
  typedef struct packed
  {
    logic        wr;
    logic [4:0]  regNum;
    logic [15:0] wdata;
    logic [15:0] exp;
    logic [6:0]  flags;
  } pbmc_row_s;
  localparam logic [4:0] PHYAD = 5'h01;
  // register, written word, expected readback, expected control levels
  localparam pbmc_row_s ROWS [14] = '{
    '{1'b0, 5'h00, 16'h0000, 16'h2100, 7'h30},
    '{1'b0, 5'h01, 16'h0000, STATUS_FIXED, 7'h30},
    '{1'b0, 5'h02, 16'h0000, ID_HIGH_VALUE, 7'h30},
    '{1'b0, 5'h03, 16'h0000, ID_LOW_VALUE, 7'h30},
    '{1'b1, 5'h04, 16'h05e1, 16'h05e1, 7'h30},
    '{1'b0, 5'h05, 16'h0000, 16'hc5e1, 7'h30},
    '{1'b1, 5'h09, 16'hffff, 16'h0000, 7'h30},
    '{1'b1, 5'h06, 16'hffff, 16'h0000, 7'h30},
    '{1'b1, 5'h1e, 16'h0003, 16'h0003, 7'h30},
    '{1'b1, 5'h1f, 16'hbeef, 16'hbeef, 7'h30},
    '{1'b1, 5'h00, 16'h4000, 16'h4000, 7'h40},
    '{1'b1, 5'h00, 16'h21bf, 16'h2180, 7'h31},
    '{1'b1, 5'h00, 16'h2940, 16'h2940, 7'h14},
    '{1'b1, 5'h00, 16'h1000, 16'h1000, 7'h08}};
  logic        sys_clk, nrst, strapAutonegEnable, mdcPin, mdioIn, mdioOut, mdioOeN;
  logic        anComplete, anSpeed100, anFullDuplex, linkUp, remoteFaultIn, jabberIn;
  logic        transmitControlIn, txCtlCore, coreRxClk, coreRxCtl, mgrOut, mgrOeN;
  logic        receiveClockOut, receiveClockOeN, receiveControlOut, receiveControlOeN;
  logic        rxDataOeN, phyStateReset, loopbackEn, speed100, fullDuplex, autonegEnable;
  logic        autonegRestart, powerDown, isolate, collisionTest;
  logic [1:0]  strapPhyAddr;
  logic [3:0]  txDataPin, txDataCore, coreRxData, rxDataOut;
  logic [6:0]  outFlags;
  logic [15:0] partnerAbility, got;
  int          numErrors, comparisons, pulses, srstLen;

  // line with pull-up: manager, then device, else high
  assign mdioIn = !mgrOeN ? mgrOut : (mdioOeN === 1'b0 ? mdioOut : 1'b1);
  assign outFlags = {loopbackEn, speed100, fullDuplex, autonegEnable, powerDown, isolate,
                     collisionTest};

  pbmc_regs i_dut (.sys_clk, .nrst, .mdcPin, .mdioIn, .mdioOut, .mdioOeN, .strapAutonegEnable,
    .strapPhyAddr, .anComplete, .anSpeed100, .anFullDuplex, .linkUp, .remoteFaultIn, .jabberIn,
    .partnerAbility, .txDataPin, .transmitControlIn, .txDataCore, .txCtlCore, .coreRxClk,
    .coreRxCtl, .coreRxData, .receiveClockOut, .receiveClockOeN, .receiveControlOut,
    .receiveControlOeN, .rxDataOut, .rxDataOeN, .phyStateReset, .loopbackEn, .speed100,
    .fullDuplex, .autonegEnable, .autonegRestart, .powerDown, .isolate, .collisionTest);
  pbmc_mgr_model i_mgr (.sys_clk, .mdioLine(mdioIn), .mdcPin, .mgrOut, .mgrOeN);

  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // restart pulses and soft reset cycles seen at the outputs
  always @(posedge sys_clk)
  begin
    if (autonegRestart === 1'b1)
      pulses++;
    if (phyStateReset === 1'b1)
      srstLen++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      numErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    logic [15:0] x;
    i_mgr.frame(PHYAD, 1'b0, r, d, x);
  endtask

  task automatic rd(input logic [4:0] r, output logic [15:0] d);
    i_mgr.frame(PHYAD, 1'b1, r, 16'h0000, d);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard
  initial
  begin
    #2_000_000;
    $display("unexpected hang at %0t: got %h expected %h", $time, 1'b1, 1'b0);
    numErrors++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    nrst = 1'b0;
    strapAutonegEnable = 1'b0;
    strapPhyAddr = 2'b01;
    {anComplete, anSpeed100, anFullDuplex, linkUp, remoteFaultIn, jabberIn} = 6'h00;
    partnerAbility = 16'hc5e1;
    {txDataPin, transmitControlIn, coreRxClk, coreRxCtl, coreRxData} = 11'h000;
    numErrors = 0;
    comparisons = 0;
    pulses = 0;
    srstLen = 0;
    tick(6);
    check({13'h0, mdioOeN, phyStateReset, autonegRestart}, 16'h0004);
    nrst = 1'b1;
    tick(12);
    foreach (ROWS[i])
    begin
      if (ROWS[i].wr)
        wr(ROWS[i].regNum, ROWS[i].wdata);
      rd(ROWS[i].regNum, got);
      check(got, ROWS[i].exp);
      check({9'h0, outFlags}, {9'h0, ROWS[i].flags});
    end
    $display("test table done");
    {anComplete, anSpeed100, anFullDuplex, linkUp} = 4'hf;
    rd(REG_CONTROL, got);
    check(got, 16'h3100);
    check({14'h0, speed100, fullDuplex}, 16'h0003);
    {anSpeed100, anFullDuplex} = 2'b00;
    wr(REG_CONTROL, 16'h0100);
    check({14'h0, speed100, fullDuplex}, 16'h0001);
    {anComplete, linkUp} = 2'b00;
    pulses = 0;
    wr(REG_CONTROL, 16'h1200);
    check(pulses[15:0], 16'h0001);
    rd(REG_CONTROL, got);
    check(got, 16'h1000);
    $display("test negotiation done");
    {txDataPin, transmitControlIn, coreRxClk, coreRxCtl, coreRxData} = 11'h579;
    wr(REG_CONTROL, 16'h0400);
    check({rxDataOeN, receiveClockOeN, receiveControlOeN, txCtlCore, txDataCore,
           receiveClockOut, receiveControlOut, rxDataOut, 2'h0}, 16'he0e4);
    rd(REG_CONTROL, got);
    check(got, 16'h0400);
    wr(REG_CONTROL, 16'h0000);
    check({rxDataOeN, receiveClockOeN, receiveControlOeN, txCtlCore, txDataCore,
           receiveClockOut, receiveControlOut, rxDataOut, 2'h0}, 16'h1ae4);
    i_mgr.frame(5'h07, 1'b0, REG_CONTROL, 16'h4000, got);
    i_mgr.frame(5'h07, 1'b1, REG_CONTROL, 16'h0000, got);
    check(got, 16'hffff);
    rd(REG_CONTROL, got);
    check(got, 16'h0000);
    $display("test isolate done");
    wr(REG_CONTROL, 16'h4880);
    strapAutonegEnable = 1'b1;
    remoteFaultIn = 1'b1;
    tick(1);
    remoteFaultIn = 1'b0;
    srstLen = 0;
    wr(REG_CONTROL, 16'h8000);
    tick(4000);
    check(srstLen[15:0], 16'(SOFT_RESET_CYCLES));
    rd(REG_CONTROL, got);
    check(got, 16'h2100);
    rd(REG_STATUS, got);
    check(got, STATUS_FIXED);
    $display("test soft reset done");
    nrst = 1'b0;
    tick(6);
    nrst = 1'b1;
    tick(12);
    rd(REG_CONTROL, got);
    check(got, 16'h3100);
    $display("test strap done");
    wrap_up();
  end
endmodule
`default_nettype wire
